// ---- hw/rfft_defs.vh ----
// Shared constants for the 1024-point radix-4 transform core
// What this block does
// - Compute forward or inverse DFT over 1024 complex samples per transform.
// - Input samples have 16-bit two's complement real and imaginary parts.
// - Results carry 16-bit real and imaginary parts, 1024 per transform.
// - Use radix-4 decimation-in-frequency butterflies, four in and four out.
// - Five ranks per transform, 256 butterflies in each rank.
// - Butterflies read four values and write results to the same addresses.
// - Twiddle factors are generated internally with 16-bit precision.
// - Generate all working RAM controls: addresses, enables, write enables.
// - Divide butterfly results by four on every pass before storing.
// - Scale select high adds one extra halving on first pass writes only.
// - Overall gain is 1/1024, or 1/2048 with scale select high.
// - Scale select acts the same for forward and inverse transforms.
// - Inverse uses positive twiddle exponent; per-pass scaling gives 1/N.
// - Samples enter and results leave in natural order; reordering is internal.
// - Three memory configurations; dual and triple overlap load, compute, unload.
// - Direction one is forward, zero inverse; sampled when each transform launches.
// - Dual and triple configurations resample scale select at each automatic launch.
// - State advances on rising edge with clock enable; active-high reset clears it.
`ifndef RFFT_DEFS_VH
`define RFFT_DEFS_VH
`define RFFT_AW          10
`define RFFT_DW          16
`define RFFT_LAST_STAGE  3'h4
`define RFFT_LAST_BFLY   8'hff
`define RFFT_LAST_ADDR   10'h3ff
`define RFFT_LAST_READ   3'h5
`define RFFT_CFG_SINGLE  2'h0
`define RFFT_CFG_DUAL    2'h1
`define RFFT_CFG_TRIPLE  2'h2
`define RFFT_PASS_SHIFT  2'h2
`define RFFT_CORDIC_K    18'h04dba
`define RFFT_CORDIC_LAST 4'he
`define RFFT_QUARTER     16'h4000
`define RFFT_TW_FRAC     15
`endif

// ---- hw/rfft_core.v ----
// Radix-4 DIF 1024-point FFT/IFFT engine with two working banks and natural-order I/O
`timescale 1ns/100ps
`include "rfft_defs.vh"
module rfft_core (
    input  wire        clock,
    input  wire        srst,
    input  wire        clock_enable,
    input  wire        start,
    input  wire        direction_select,
    input  wire        scale_select,
    input  wire        memory_config_select_lo,
    input  wire        memory_config_select_hi,
    input  wire        input_write_strobe,
    input  wire [15:0] data_in_re,
    input  wire [15:0] data_in_im,
    input  wire        result_read_strobe,
    output wire [15:0] result_re,
    output wire [15:0] result_im,
    output wire [9:0]  result_index,
    output wire        result_valid,
    output wire        busy,
    output wire        done,
    output wire        active_bank,
    output wire [9:0]  bank_x_read_address,
    output wire [9:0]  bank_x_write_address,
    output wire        bank_x_enable,
    output wire        bank_x_write_enable,
    output wire [9:0]  bank_y_read_address,
    output wire [9:0]  bank_y_write_address,
    output wire        bank_y_enable,
    output wire        bank_y_write_enable
);
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_TWID = 2'h2;
    localparam ST_MULW = 2'h3;

    reg [1:0]         state_q;
    reg [2:0]         stage_q;
    reg [7:0]         bf_q;
    reg [1:0]         leg_q;
    reg [2:0]         cnt_q;
    reg [3:0]         it_q;
    reg               busy_q;
    reg               done_q;
    reg               dir_q;
    reg               scl_q;
    reg               eb_q;
    reg               full_q;
    reg [9:0]         in_cnt_q;
    reg [9:0]         out_cnt_q;
    reg signed [15:0] a_re_q [0:3];
    reg signed [15:0] a_im_q [0:3];
    reg signed [17:0] cx_q;
    reg signed [17:0] cy_q;
    reg signed [15:0] cz_q;
    reg [9:0]         rad_q [0:1];
    reg [9:0]         wad_q [0:1];
    reg               we_q [0:1];
    reg               en_q [0:1];
    reg [31:0]        wdat_q [0:1];
    reg [31:0]        rdat_q [0:1];
    reg [31:0]        mem [0:2047];
    reg               p1_q;
    reg               p2_q;
    reg               pb1_q;
    reg               pb2_q;
    reg [9:0]         pi1_q;
    reg [9:0]         pi2_q;
    reg [15:0]        res_re_q;
    reg [15:0]        res_im_q;
    reg [9:0]         res_idx_q;
    reg               res_vld_q;
    integer           b;
    integer           g;
    integer           r;

    // Address of one butterfly leg: group above the split, leg digit, offset below
    function [9:0] leg_addr;
        input [7:0] bf;
        input [1:0] leg;
        input [2:0] stg;
        reg [3:0] p;
        reg [9:0] bb;
        begin
            p = 4'h8 - {stg, 1'b0};
            bb = {2'h0, bf};
            leg_addr = ((bb >> p) << (p + 4'h2)) | ({8'h00, leg} << p) | (bb & ((10'h001 << p) - 10'h001));
        end
    endfunction

    // Twiddle phase on a 16-bit circle: exponent leg*j scaled by 4^stage, mod N
    function [15:0] twid_phase;
        input [7:0] bf;
        input [1:0] leg;
        input [2:0] stg;
        reg [3:0] p;
        reg [9:0] j;
        reg [9:0] e;
        begin
            p = 4'h8 - {stg, 1'b0};
            j = {2'h0, bf} & ((10'h001 << p) - 10'h001);
            e = ({8'h00, leg} * j) << {stg, 1'b0};
            twid_phase = {e, 6'h00};
        end
    endfunction

    // Arctangent of 2^-i in the same 16-bit phase units
    function [15:0] atan_step;
        input [3:0] i;
        begin
            case (i)
                4'h0: atan_step = 16'h2000;
                4'h1: atan_step = 16'h12e4;
                4'h2: atan_step = 16'h09fb;
                4'h3: atan_step = 16'h0511;
                4'h4: atan_step = 16'h028b;
                4'h5: atan_step = 16'h0146;
                4'h6: atan_step = 16'h00a3;
                4'h7: atan_step = 16'h0051;
                4'h8: atan_step = 16'h0029;
                4'h9: atan_step = 16'h0014;
                4'ha: atan_step = 16'h000a;
                4'hb: atan_step = 16'h0005;
                4'hc: atan_step = 16'h0003;
                4'hd: atan_step = 16'h0001;
                4'he: atan_step = 16'h0001;
                default: atan_step = 16'h0000;
            endcase
        end
    endfunction

    // Clip a wide two's complement value into 16 bits
    function [15:0] sat16;
        input signed [33:0] v;
        begin
            if (v > 34'sh7fff)
                sat16 = 16'h7fff;
            else if (v < -34'sh8000)
                sat16 = 16'h8000;
            else
                sat16 = v[15:0];
        end
    endfunction

    wire [1:0]  cfg      = {memory_config_select_hi, memory_config_select_lo};
    wire        single   = (cfg == `RFFT_CFG_SINGLE) || (cfg == 2'h3);
    // Continuous modes start by themselves once a full vector is loaded
    wire        go       = (state_q == ST_IDLE) && (start || (!single && full_q));
    wire        wr_ok    = input_write_strobe && !(busy_q && single);
    wire        rd_ok    = result_read_strobe && !(busy_q && single);
    wire        wb       = single ? eb_q : ~eb_q;
    wire        rb       = (busy_q && !single) ? ~eb_q : eb_q;
    wire [9:0]  out_addr = {out_cnt_q[1:0], out_cnt_q[3:2], out_cnt_q[5:4], out_cnt_q[7:6], out_cnt_q[9:8]};
    wire [9:0]  eng_ra   = leg_addr(bf_q, cnt_q[1:0], stage_q);
    wire [9:0]  eng_wa   = leg_addr(bf_q, leg_q, stage_q);
    wire        eng_we   = (state_q == ST_MULW);
    wire [31:0] eng_rd   = rdat_q[eb_q];
    wire [15:0] nph      = twid_phase(bf_q, leg_q + 2'h1, stage_q);
    wire [15:0] ang      = dir_q ? (16'h0000 - nph) : nph;

    // Radix-4 DIF butterfly terms, 18 bits so four-way sums cannot wrap
    wire signed [17:0] e_re = a_re_q[0] + a_re_q[2];
    wire signed [17:0] e_im = a_im_q[0] + a_im_q[2];
    wire signed [17:0] f_re = a_re_q[0] - a_re_q[2];
    wire signed [17:0] f_im = a_im_q[0] - a_im_q[2];
    wire signed [17:0] g_re = a_re_q[1] + a_re_q[3];
    wire signed [17:0] g_im = a_im_q[1] + a_im_q[3];
    wire signed [17:0] h_re = a_re_q[1] - a_re_q[3];
    wire signed [17:0] h_im = a_im_q[1] - a_im_q[3];
    // Minus-j on leg 1 forward, plus-j inverse; leg 3 mirrors it
    wire               pos  = (leg_q == 2'h1) == dir_q;
    reg  signed [17:0] v_re;
    reg  signed [17:0] v_im;
    always @*
    begin
        case (leg_q)
            2'h0:    begin v_re = e_re + g_re; v_im = e_im + g_im; end
            2'h2:    begin v_re = e_re - g_re; v_im = e_im - g_im; end
            default: begin v_re = pos ? f_re + h_im : f_re - h_im; v_im = pos ? f_im - h_re : f_im + h_re; end
        endcase
    end

    // Per-pass divide by four, plus one more bit on the first pass if asked
    wire [1:0]         shamt = `RFFT_PASS_SHIFT + {1'b0, (stage_q == 3'h0) && scl_q};
    wire signed [17:0] vs_re = v_re >>> shamt;
    wire signed [17:0] vs_im = v_im >>> shamt;
    wire signed [15:0] tw_re = sat16({{16{cx_q[17]}}, cx_q});
    wire signed [15:0] tw_im = sat16({{16{cy_q[17]}}, cy_q});
    wire signed [15:0] s_re  = vs_re[15:0];
    wire signed [15:0] s_im  = vs_im[15:0];
    wire signed [32:0] m_re  = s_re * tw_re - s_im * tw_im;
    wire signed [32:0] m_im  = s_re * tw_im + s_im * tw_re;
    wire signed [32:0] ms_re = m_re >>> `RFFT_TW_FRAC;
    wire signed [32:0] ms_im = m_im >>> `RFFT_TW_FRAC;
    // Leg 0 has a unity twiddle, so it skips the rotator and its gain error
    wire [31:0] eng_wd = (leg_q == 2'h0) ? {s_re, s_im} :
                         {sat16({ms_re[32], ms_re}), sat16({ms_im[32], ms_im})};

    // Transform sequencer: 5 ranks of 256 butterflies, legs written in place
    always @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            stage_q <= 3'h0;
            bf_q    <= 8'h00;
            leg_q   <= 2'h0;
            cnt_q   <= 3'h0;
            it_q    <= 4'h0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            dir_q   <= 1'b1;
            scl_q   <= 1'b0;
            eb_q    <= 1'b0;
            cx_q    <= 18'h00000;
            cy_q    <= 18'h00000;
            cz_q    <= 16'h0000;
            for (g = 0; g < 4; g = g + 1)
            begin
                a_re_q[g] <= 16'h0000;
                a_im_q[g] <= 16'h0000;
            end
        end
        else if (clock_enable)
        begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (go)
                    begin
                        busy_q  <= 1'b1;
                        dir_q   <= direction_select;
                        scl_q   <= scale_select;
                        stage_q <= 3'h0;
                        bf_q    <= 8'h00;
                        cnt_q   <= 3'h0;
                        state_q <= ST_READ;
                        if (!single)
                            eb_q <= ~eb_q;
                    end
                ST_READ:
                begin
                    // Read data lands two cycles after its address is issued
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q >= 3'h2)
                    begin
                        a_re_q[cnt_q[1:0] - 2'h2] <= eng_rd[31:16];
                        a_im_q[cnt_q[1:0] - 2'h2] <= eng_rd[15:0];
                    end
                    if (cnt_q == `RFFT_LAST_READ)
                    begin
                        leg_q   <= 2'h0;
                        state_q <= ST_MULW;
                    end
                end
                ST_TWID:
                begin
                    // One rotator step per cycle towards the twiddle angle
                    it_q <= it_q + 4'h1;
                    if (!cz_q[15])
                    begin
                        cx_q <= cx_q - (cy_q >>> it_q);
                        cy_q <= cy_q + (cx_q >>> it_q);
                        cz_q <= cz_q - atan_step(it_q);
                    end
                    else
                    begin
                        cx_q <= cx_q + (cy_q >>> it_q);
                        cy_q <= cy_q - (cx_q >>> it_q);
                        cz_q <= cz_q + atan_step(it_q);
                    end
                    if (it_q == `RFFT_CORDIC_LAST)
                        state_q <= ST_MULW;
                end
                ST_MULW:
                    if (leg_q != 2'h3)
                    begin
                        // Seed the rotator, folding angles beyond a quarter turn
                        leg_q   <= leg_q + 2'h1;
                        it_q    <= 4'h0;
                        state_q <= ST_TWID;
                        if (!ang[15] && (ang > `RFFT_QUARTER))
                        begin
                            cx_q <= 18'h00000;
                            cy_q <= `RFFT_CORDIC_K;
                            cz_q <= ang - `RFFT_QUARTER;
                        end
                        else if (ang[15] && (ang < (16'h0000 - `RFFT_QUARTER)))
                        begin
                            cx_q <= 18'h00000;
                            cy_q <= 18'h00000 - `RFFT_CORDIC_K;
                            cz_q <= ang + `RFFT_QUARTER;
                        end
                        else
                        begin
                            cx_q <= `RFFT_CORDIC_K;
                            cy_q <= 18'h00000;
                            cz_q <= ang;
                        end
                    end
                    else
                    begin
                        cnt_q   <= 3'h0;
                        state_q <= ST_READ;
                        bf_q    <= bf_q + 8'h01;
                        if (bf_q == `RFFT_LAST_BFLY)
                        begin
                            stage_q <= stage_q + 3'h1;
                            if (stage_q == `RFFT_LAST_STAGE)
                            begin
                                state_q <= ST_IDLE;
                                busy_q  <= 1'b0;
                                done_q  <= 1'b1;
                            end
                        end
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Load and unload counters, plus the unload pipeline to the result port
    always @(posedge clock)
    begin
        if (srst)
        begin
            in_cnt_q  <= 10'h000;
            out_cnt_q <= 10'h000;
            full_q    <= 1'b0;
            p1_q      <= 1'b0;
            p2_q      <= 1'b0;
            pb1_q     <= 1'b0;
            pb2_q     <= 1'b0;
            pi1_q     <= 10'h000;
            pi2_q     <= 10'h000;
            res_re_q  <= 16'h0000;
            res_im_q  <= 16'h0000;
            res_idx_q <= 10'h000;
            res_vld_q <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (wr_ok)
                in_cnt_q <= in_cnt_q + 10'h001;
            // A completed load wins over the clear from a start in the same cycle
            if (wr_ok && (in_cnt_q == `RFFT_LAST_ADDR))
                full_q <= 1'b1;
            else if (go)
                full_q <= 1'b0;
            if (rd_ok)
                out_cnt_q <= out_cnt_q + 10'h001;
            p1_q  <= rd_ok;
            pb1_q <= rb;
            pi1_q <= out_cnt_q;
            p2_q  <= p1_q;
            pb2_q <= pb1_q;
            pi2_q <= pi1_q;
            res_vld_q <= p2_q;
            if (p2_q)
            begin
                res_re_q  <= rdat_q[pb2_q][31:16];
                res_im_q  <= rdat_q[pb2_q][15:0];
                res_idx_q <= pi2_q;
            end
        end
    end

    // Bank control: the engine owns its bank while busy, user I/O gets the rest
    always @(posedge clock)
    begin
        if (srst)
        begin
            for (b = 0; b < 2; b = b + 1)
            begin
                rad_q[b]  <= 10'h000;
                wad_q[b]  <= 10'h000;
                we_q[b]   <= 1'b0;
                en_q[b]   <= 1'b0;
                wdat_q[b] <= 32'h00000000;
            end
        end
        else if (clock_enable)
        begin
            for (b = 0; b < 2; b = b + 1)
            begin
                if (busy_q && (eb_q == b[0]))
                begin
                    rad_q[b]  <= eng_ra;
                    wad_q[b]  <= eng_wa;
                    we_q[b]   <= eng_we;
                    en_q[b]   <= 1'b1;
                    wdat_q[b] <= eng_wd;
                end
                else
                begin
                    rad_q[b]  <= out_addr;
                    wad_q[b]  <= in_cnt_q;
                    we_q[b]   <= wr_ok && (wb == b[0]);
                    en_q[b]   <= (wr_ok && (wb == b[0])) || (rd_ok && (rb == b[0]));
                    wdat_q[b] <= {data_in_re, data_in_im};
                end
            end
        end
    end

    // Dual-port working RAM, one write and one registered read per bank
    always @(posedge clock)
    begin
        if (clock_enable)
        begin
            for (r = 0; r < 2; r = r + 1)
            begin
                if (en_q[r])
                begin
                    if (we_q[r])
                        mem[{r[0], wad_q[r]}] <= wdat_q[r];
                    rdat_q[r] <= mem[{r[0], rad_q[r]}];
                end
            end
        end
    end

    assign result_re            = res_re_q;
    assign result_im            = res_im_q;
    assign result_index         = res_idx_q;
    assign result_valid         = res_vld_q;
    assign busy                 = busy_q;
    assign done                 = done_q;
    assign active_bank          = eb_q;
    assign bank_x_read_address  = rad_q[0];
    assign bank_x_write_address = wad_q[0];
    assign bank_x_enable        = en_q[0];
    assign bank_x_write_enable  = we_q[0];
    assign bank_y_read_address  = rad_q[1];
    assign bank_y_write_address = wad_q[1];
    assign bank_y_enable        = en_q[1];
    assign bank_y_write_enable  = we_q[1];
endmodule // rfft_core

// ---- tb/rfft_core_chk.sv ----
// Port-level assertions for the transform core
`timescale 1ns/100ps
module rfft_core_chk (
    input wire       clock,
    input wire       srst,
    input wire       clock_enable,
    input wire       start,
    input wire       memory_config_select_lo,
    input wire       memory_config_select_hi,
    input wire       input_write_strobe,
    input wire       result_read_strobe,
    input wire [9:0] result_index,
    input wire       result_valid,
    input wire       busy,
    input wire       done,
    input wire       active_bank,
    input wire       bank_x_enable,
    input wire       bank_x_write_enable
);
    wire        single = memory_config_select_lo == memory_config_select_hi;
    reg  [9:0]  next_idx_q;
    reg  [16:0] run_q;
    // Next natural index due, and enabled cycles spent busy; a frozen enable stalls both
    always @(posedge clock)
    begin
        if (srst)
        begin
            next_idx_q <= 10'h000;
            run_q      <= 17'h00000;
        end
        else if (clock_enable)
        begin
            if (result_valid)
                next_idx_q <= result_index + 10'h001;
            run_q <= busy ? run_q + 17'h00001 : 17'h00000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    reset_clears_a: assert property (disable iff (1'b0) srst && clock_enable |=> !busy && !result_valid
        && !done && !active_bank) else $error("outputs not cleared by reset");
    start_busy_a: assert property (start && clock_enable && !busy |=> busy)
        else $error("start did not launch a transform");
    done_falls_a: assert property (!$past(srst) && $fell(busy) |-> done)
        else $error("busy dropped without done");
    run_length_a: assert property (done |-> run_q == 17'h11300)
        else $error("transform not five ranks of 256 butterflies");
    read_latency_a: assert property (result_read_strobe && clock_enable && !busy ##1 clock_enable [*2]
        |=> result_valid) else $error("result not three cycles after read strobe");
    read_refused_a: assert property ((busy && single) [*4] |-> !result_valid)
        else $error("result delivered while busy in single configuration");
    index_order_a: assert property (result_valid |-> result_index == next_idx_q)
        else $error("results not in natural order");
    load_write_a: assert property (input_write_strobe && clock_enable && !busy && single && !active_bank
        |=> bank_x_write_enable && bank_x_enable) else $error("accepted sample not written to bank");
endmodule // rfft_core_chk

bind rfft_core rfft_core_chk chk_i (
    .clock(clock), .srst(srst), .clock_enable(clock_enable), .start(start),
    .memory_config_select_lo(memory_config_select_lo), .memory_config_select_hi(memory_config_select_hi),
    .input_write_strobe(input_write_strobe), .result_read_strobe(result_read_strobe),
    .result_index(result_index), .result_valid(result_valid), .busy(busy), .done(done),
    .active_bank(active_bank), .bank_x_enable(bank_x_enable), .bank_x_write_enable(bank_x_write_enable)
);

// ---- tb/rfft_user_model.sv ----
// Behavioural user logic: feeds a complex tone, makes refused traffic, pulls results
`timescale 1ns/100ps
module rfft_user_model (
    input  wire        clock,
    output reg         clock_enable,
    output reg         input_write_strobe,
    output reg  [15:0] data_in_re,
    output reg  [15:0] data_in_im,
    output reg         result_read_strobe
);
    integer seed;
    integer n;
    real    ph;
    // Quiet strobes and running enable at time zero
    initial
    begin
        seed               = 32'h9a2f;
        clock_enable       = 1'b1;
        input_write_strobe = 1'b0;
        result_read_strobe = 1'b0;
        data_in_re         = 16'h0000;
        data_in_im         = 16'h0000;
    end
    // One cycle; a strobe counts only on an enabled edge, idle data lines toggle so stale values never match
    task beat(input wr, input rd, input rnd);
        begin
            clock_enable       = rnd ? (($random(seed) % 8) != 0) : 1'b1;
            input_write_strobe = wr;
            result_read_strobe = rd;
            if (!wr)
            begin
                data_in_re = ~data_in_re;
                data_in_im = ~data_in_im;
            end
            @(posedge clock);
            if (clock_enable && (wr || rd))
                n = n + 1;
            #1;
        end
    endtask
    // Natural-order tone a*exp(+j*2pi*m*n/1024), with random gaps and stalls
    task load(input [9:0] m, input [15:0] a);
        begin
            n = 0;
            while (n < 1024)
            begin
                ph = 6.283185307179586 * m * n / 1024.0;
                if ($random(seed) % 4 != 0)
                begin
                    data_in_re = $rtoi(a * $cos(ph));
                    data_in_im = $rtoi(a * $sin(ph));
                    beat(1'b1, 1'b0, 1'b1);
                end
                else
                    beat(1'b0, 1'b0, 1'b1);
            end
            input_write_strobe = 1'b0;
            clock_enable       = 1'b1;
        end
    endtask
    // Random writes and reads that a busy single-bank engine must ignore
    task poke(input integer k);
        begin
            repeat (k)
                beat($random(seed), $random(seed), 1'b0);
            input_write_strobe = 1'b0;
            result_read_strobe = 1'b0;
        end
    endtask
    // Pull 1024 results with random gaps and stalls
    task unload;
        begin
            n = 0;
            while (n < 1024)
                beat(1'b0, ($random(seed) % 4) != 0, 1'b1);
            result_read_strobe = 1'b0;
            clock_enable       = 1'b1;
        end
    endtask
endmodule // rfft_user_model

// ---- tb/rfft_core_tb_top.sv ----
// Self-checking bench: one random tone through the core, refused traffic, natural-order unload
`timescale 1ns/100ps
module rfft_core_tb_top;
    reg         clock;
    reg         srst;
    reg         start;
    reg         direction_select;
    reg         scale_select;
    reg         dual;
    wire        clock_enable;
    wire        input_write_strobe;
    wire        result_read_strobe;
    wire [15:0] data_in_re;
    wire [15:0] data_in_im;
    wire [15:0] result_re;
    wire [15:0] result_im;
    wire [9:0]  result_index;
    wire        result_valid;
    wire        busy;
    wire        done;
    wire        active_bank;
    integer     errors;
    integer     cmp_count;
    integer     seed;
    integer     got;
    integer     i;
    reg  [9:0]  tone;
    reg  [9:0]  peak;
    reg  [15:0] amp;

    rfft_core dut (.clock(clock), .srst(srst), .clock_enable(clock_enable), .start(start),
        .direction_select(direction_select), .scale_select(scale_select), .memory_config_select_lo(dual),
        .memory_config_select_hi(1'b0), .input_write_strobe(input_write_strobe), .data_in_re(data_in_re),
        .data_in_im(data_in_im), .result_read_strobe(result_read_strobe), .result_re(result_re),
        .result_im(result_im), .result_index(result_index), .result_valid(result_valid), .busy(busy),
        .done(done), .active_bank(active_bank), .bank_x_read_address(), .bank_x_write_address(), .bank_x_enable(),
        .bank_x_write_enable(), .bank_y_read_address(), .bank_y_write_address(), .bank_y_enable(),
        .bank_y_write_enable());
    rfft_user_model user (.clock(clock), .clock_enable(clock_enable), .input_write_strobe(input_write_strobe),
        .data_in_re(data_in_re), .data_in_im(data_in_im), .result_read_strobe(result_read_strobe));

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Compare within a tolerance; the rotator and truncation leave a few LSB of error
    task chk(input [15:0] seen, input [15:0] want, input [15:0] tol);
        reg signed [17:0] d;
        begin
            d = $signed({2'b00, seen}) - $signed({2'b00, want});
            if (want == 16'h0000 || seen[15])
                d = $signed({{2{seen[15]}}, seen}) - $signed({{2{want[15]}}, want});
            cmp_count = cmp_count + 1;
            if (((d <= $signed({2'b00, tol})) && (d >= -$signed({2'b00, tol}))) !== 1'b1)
            begin
                errors = errors + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task test_done;
        begin
            $display("compares %0d errors %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // A tone lands as one bin of height amp; halved when the extra first-pass shift is on
    function [15:0] want_re(input [9:0] k);
        want_re = (k == peak) ? (scale_select ? amp >> 1 : amp) : 16'h0000;
    endfunction
    // Each delivered result, checked mid-cycle where it is settled
    always @(negedge clock)
    begin
        if (result_valid === 1'b1 && clock_enable && !srst)
        begin
            chk({6'h00, result_index}, got[15:0], 16'h0000);
            chk(result_re, want_re(got[9:0]), 16'h0006);
            chk(result_im, 16'h0000, 16'h0006);
            got = got + 1;
        end
    end
    // Watchdog: a transform is about 70400 cycles plus load and unload
    initial
    begin
        repeat (100000) @(posedge clock);
        errors = errors + 1;
        test_done;
    end
    initial
    begin
        errors = 0;
        cmp_count = 0;
        seed = 32'h9a2f;
        got = 0;
        srst = 1'b1;
        start = 1'b0;
        dual = 1'b0;
        direction_select = $random(seed);
        scale_select = $random(seed);
        tone = $random(seed);
        amp = 16'h1800 + ($random(seed) & 16'h07ff);
        peak = direction_select ? tone : 10'h000 - tone;
        repeat (12) @(posedge clock);
        #1 srst = 1'b0;
        user.load(tone, amp);
        start = 1'b1;
        @(posedge clock);
        #1 start = 1'b0;
        chk({15'h0000, busy}, 16'h0001, 16'h0000);
        @(posedge clock);
        #1 start = 1'b1;
        @(posedge clock);
        #1 start = 1'b0;
        user.poke(40);
        i = 0;
        while (done !== 1'b1 && i < 80000)
        begin
            @(posedge clock);
            #1 i = i + 1;
        end
        chk({15'h0000, done}, 16'h0001, 16'h0000);
        user.unload;
        repeat (8) @(posedge clock);
        chk(got[15:0], 16'h0400, 16'h0000);
        #1 dual = 1'b1;
        user.load(tone, amp);
        @(posedge clock);
        #1 chk({14'h0000, busy, active_bank}, 16'h0003, 16'h0000);
        test_done;
    end
endmodule // rfft_core_tb_top
